// ==== hdl/usi_pkg.sv ====
// Constants for the USB device status and interrupt register block
package usi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  OFS_MAIN      = 4'h0;
  localparam logic [3:0]  OFS_SRC_EN    = 4'h2;
  localparam logic [3:0]  OFS_IRQ_EN    = 4'h4;
  localparam logic [3:0]  OFS_CLK_CTRL  = 4'h6;
  localparam logic [3:0]  OFS_PIPE_CTRL = 4'h8;

  // ----------------------------------------------------------------
  // Main status register fields
  // ----------------------------------------------------------------
  localparam int BIT_VBUS_CHG   = 15;
  localparam int BIT_RESUME     = 14;
  localparam int BIT_DEV_CHG    = 12;
  localparam int BIT_CTRL_CHG   = 11;
  localparam int BIT_EMPTY_SUM  = 10;
  localparam int BIT_NRDY_SUM   = 9;
  localparam int BIT_RDY_SUM    = 8;
  localparam int BIT_VBUS_LVL   = 7;
  localparam int DEV_STATE_LSB  = 4;
  localparam int BIT_SETUP_RCV  = 3;
  localparam int CTRL_STAGE_LSB = 0;

  // ----------------------------------------------------------------
  // Source enable register fields
  // ----------------------------------------------------------------
  localparam int SRC_EN_RESET   = 0;
  localparam int SRC_EN_ADDR    = 1;
  localparam int SRC_EN_CONFIG  = 2;
  localparam int SRC_EN_SUSPEND = 3;
  localparam int SRC_EN_WSTS    = 4;
  localparam int SRC_EN_RSTS    = 5;
  localparam int SRC_EN_DONE    = 6;
  localparam int SRC_EN_SEQERR  = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  SRC_EN_RST    = 8'hFF;
  localparam logic [15:0] IRQ_EN_RST    = 16'h0000;
  localparam logic        CLK_SUPPLY_RST = 1'b1;
  localparam logic [1:0]  HSHAKE_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Bus line states
  // ----------------------------------------------------------------
  localparam logic [1:0]  LINE_SE0      = 2'h0;
  localparam logic [1:0]  LINE_J        = 2'h1;
  localparam logic [1:0]  LINE_K        = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 20;
  localparam int CLEAR_SPACING_NS  = 100;
  localparam int CLEAR_SPACING_CYC = (CLEAR_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    USI_DEV_POWERED    = 3'b000,
    USI_DEV_DEFAULT    = 3'b001,
    USI_DEV_ADDRESS    = 3'b010,
    USI_DEV_CONFIGURED = 3'b011,
    USI_DEV_SUSPENDED  = 3'b100
  } usi_dev_state_e;

  typedef enum logic [2:0] {
    USI_CS_IDLE     = 3'b000,
    USI_CS_RD_DATA  = 3'b001,
    USI_CS_RD_STS   = 3'b010,
    USI_CS_WR_DATA  = 3'b011,
    USI_CS_WR_STS   = 3'b100,
    USI_CS_ND_STS   = 3'b101,
    USI_CS_SEQ_ERR  = 3'b110,
    USI_CS_RESERVED = 3'b111
  } usi_ctrl_stage_e;

endpackage

// ==== hdl/usi_status.sv ====
// USB device main event status register with device state and control stage tracking
// Overview of operation
// - VBUS edge either way sets bit 15
// - Zero clears; clock stopped needs zero then one
// - J to K or SE0 while suspended sets 14
// - Four enabled device-state sources set bit 12
// - Zero clears 12/11/3 only with clock running
// - Five stage sources set 11, four maskable
// - Bit 10 is OR of empty/overflow flags
// - Bit 9 is OR of not-ready flags
// - Bit 8 is OR of ready flags
// - Bit 7 live VBUS; change sets bit 15
// - Reset gives Powered, bus reset gives Default
// - SET_ADDRESS: nonzero Address, zero Default
// - SET_CONFIGURATION: nonzero Configured, zero Address
// - Suspend detection moves state to Suspended
// - Setup packet received sets bit 3, no interrupt
// - Handshake field writes ignored while bit 3 set
// - Bits 2..0 report current control stage
// - One write may clear 12 and 11 together
// - Stage codes 000..110, 111 reserved
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
module usi_status
  import usi_pkg::*;
#(
  parameter int NUM_PIPES = 6
)
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  sw_reset_i,
  // Register port
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [15:0]           wdata_i,
  input  wire logic                  we_i,
  input  wire logic                  re_i,
  output logic      [15:0]           rdata_o,
  // Bus line pins
  input  wire logic                  vbus_i,
  input  wire logic [1:0]            line_state_i,
  // Protocol engine events
  input  wire logic                  usb_reset_det_i,
  input  wire logic                  set_address_exec_i,
  input  wire logic                  address_nonzero_i,
  input  wire logic                  set_config_exec_i,
  input  wire logic                  config_nonzero_i,
  input  wire logic                  suspend_det_i,
  input  wire logic                  setup_done_i,
  input  wire logic [2:0]            ctrl_stage_i,
  // Per-pipe flags
  input  wire logic [NUM_PIPES-1:0]  pipe_empty_overflow_flags_i,
  input  wire logic                  ctrl_pipe_empty_overflow_flag_i,
  input  wire logic [NUM_PIPES-1:0]  pipe_not_ready_flags_i,
  input  wire logic                  ctrl_pipe_not_ready_flag_i,
  input  wire logic [NUM_PIPES-1:0]  pipe_ready_flags_i,
  input  wire logic                  ctrl_pipe_ready_flag_i,
  // Block outputs
  output logic [1:0]                 response_handshake_field_o,
  output logic                       internal_clock_supply_bit_o,
  output logic [2:0]                 device_state_field_o,
  output logic                       irq_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] vbus_sync;
  logic [1:0] line_s1, line_s2, line_s3;
  logic [1:0] line_stable, next_line_stable;
  logic       vbus_stable, next_vbus_stable, vbus_edge, resume_event;

  always_comb
  begin
    next_vbus_stable = vbus_stable;
    next_line_stable = line_stable;
    vbus_edge        = 1'b0;
    resume_event     = 1'b0;
    if ((vbus_sync[1] == vbus_sync[2]) && (vbus_sync[2] != vbus_stable))
    begin
      next_vbus_stable = vbus_sync[2];
      vbus_edge        = 1'b1;
    end
    if ((line_s2 == line_s3) && (line_s3 != line_stable))
    begin
      next_line_stable = line_s3;
      if ((line_stable == LINE_J) && ((line_s3 == LINE_K) || (line_s3 == LINE_SE0))
          && device_state_field_o[2])
        resume_event = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      vbus_sync   <= 3'h0;
      line_s1     <= LINE_J;
      line_s2     <= LINE_J;
      line_s3     <= LINE_J;
      vbus_stable <= 1'b0;
      line_stable <= LINE_J;
    end
    else
    begin
      vbus_sync   <= {vbus_sync[1:0], vbus_i};
      line_s1     <= line_state_i;
      line_s2     <= line_s1;
      line_s3     <= line_s2;
      vbus_stable <= next_vbus_stable;
      line_stable <= next_line_stable;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0]  src_en, next_src_en;
  logic [15:0] irq_en, next_irq_en;
  logic [1:0]  hshake, next_hshake;
  logic        clk_supply, next_clk_supply, setup_rcv;

  always_comb
  begin
    next_src_en     = src_en;
    next_irq_en     = irq_en;
    next_clk_supply = clk_supply;
    next_hshake     = hshake;
    if (we_i)
    begin
      unique case (addr_i)
        OFS_SRC_EN:   next_src_en = wdata_i[7:0];
        OFS_IRQ_EN:   next_irq_en = wdata_i;
        OFS_CLK_CTRL: next_clk_supply = wdata_i[0];
        OFS_PIPE_CTRL:
        begin
          if (!setup_rcv)
            next_hshake = wdata_i[1:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      src_en     <= SRC_EN_RST;
      irq_en     <= IRQ_EN_RST;
      clk_supply <= CLK_SUPPLY_RST;
      hshake     <= HSHAKE_RST;
    end
    else
    begin
      src_en     <= sw_reset_i ? SRC_EN_RST : next_src_en;
      irq_en     <= sw_reset_i ? IRQ_EN_RST : next_irq_en;
      clk_supply <= sw_reset_i ? CLK_SUPPLY_RST : next_clk_supply;
      hshake     <= sw_reset_i ? HSHAKE_RST : next_hshake;
    end
  end

  assign response_handshake_field_o  = hshake;
  assign internal_clock_supply_bit_o = clk_supply;

  // ----------------------------------------------------------------
  // Device state and control stage tracking
  // ----------------------------------------------------------------
  usi_dev_state_e dev_state, saved_state, next_dev_state, next_saved_state;
  logic [2:0]     ctrl_stage, next_ctrl_stage;
  logic           dev_event, stage_event;

  always_comb
  begin
    next_dev_state   = dev_state;
    next_saved_state = saved_state;
    dev_event        = 1'b0;
    if (usb_reset_det_i)
    begin
      next_dev_state = USI_DEV_DEFAULT;
      dev_event      = src_en[SRC_EN_RESET];
    end
    else if (suspend_det_i && (dev_state != USI_DEV_SUSPENDED))
    begin
      next_saved_state = dev_state;
      next_dev_state   = USI_DEV_SUSPENDED;
      dev_event        = src_en[SRC_EN_SUSPEND];
    end
    else if (resume_event)
      next_dev_state = saved_state;
    else if (set_address_exec_i)
    begin
      next_dev_state = address_nonzero_i ? USI_DEV_ADDRESS : USI_DEV_DEFAULT;
      dev_event      = src_en[SRC_EN_ADDR];
    end
    else if (set_config_exec_i)
    begin
      next_dev_state = config_nonzero_i ? USI_DEV_CONFIGURED : USI_DEV_ADDRESS;
      dev_event      = src_en[SRC_EN_CONFIG];
    end
  end

  // Stage transitions of the control transfer raise the stage-change sources
  always_comb
  begin
    next_ctrl_stage = ctrl_stage_i;
    stage_event     = 1'b0;
    if (setup_done_i)
      stage_event = 1'b1;
    if (ctrl_stage_i != ctrl_stage)
    begin
      unique case (ctrl_stage_i)
        USI_CS_WR_STS,
        USI_CS_ND_STS:  stage_event = stage_event | src_en[SRC_EN_WSTS];
        USI_CS_RD_STS:  stage_event = stage_event | src_en[SRC_EN_RSTS];
        USI_CS_SEQ_ERR: stage_event = stage_event | src_en[SRC_EN_SEQERR];
        USI_CS_IDLE:
        begin
          if ((ctrl_stage == USI_CS_RD_STS) || (ctrl_stage == USI_CS_WR_STS)
              || (ctrl_stage == USI_CS_ND_STS))
            stage_event = stage_event | src_en[SRC_EN_DONE];
        end
        USI_CS_RESERVED: next_ctrl_stage = ctrl_stage;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dev_state   <= USI_DEV_POWERED;
      saved_state <= USI_DEV_POWERED;
      ctrl_stage  <= USI_CS_IDLE;
    end
    else
    begin
      dev_state   <= sw_reset_i ? USI_DEV_POWERED : next_dev_state;
      saved_state <= sw_reset_i ? USI_DEV_POWERED : next_saved_state;
      ctrl_stage  <= sw_reset_i ? USI_CS_IDLE : next_ctrl_stage;
    end
  end

  assign device_state_field_o = dev_state;

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic vbus_chg, resume, dev_chg, ctrl_chg, vbus_arm, resume_arm, main_wr;
  logic next_vbus_chg, next_resume, next_dev_chg, next_ctrl_chg;
  logic next_setup_rcv, next_vbus_arm, next_resume_arm;

  assign main_wr = we_i && (addr_i == OFS_MAIN);

  // Set always wins over a clear arriving in the same cycle
  always_comb
  begin
    next_vbus_chg   = vbus_chg;
    next_resume     = resume;
    next_dev_chg    = dev_chg;
    next_ctrl_chg   = ctrl_chg;
    next_setup_rcv  = setup_rcv;
    next_vbus_arm   = vbus_arm;
    next_resume_arm = resume_arm;
    if (main_wr)
    begin
      if (clk_supply)
      begin
        next_vbus_arm   = 1'b0;
        next_resume_arm = 1'b0;
        if (!wdata_i[BIT_VBUS_CHG])
          next_vbus_chg = 1'b0;
        if (!wdata_i[BIT_RESUME])
          next_resume = 1'b0;
        if (!wdata_i[BIT_DEV_CHG])
          next_dev_chg = 1'b0;
        if (!wdata_i[BIT_CTRL_CHG])
          next_ctrl_chg = 1'b0;
        if (!wdata_i[BIT_SETUP_RCV])
          next_setup_rcv = 1'b0;
      end
      else
      begin
        // Clock stopped: a zero only arms, the following one completes the clear
        if (!wdata_i[BIT_VBUS_CHG])
          next_vbus_arm = 1'b1;
        else if (vbus_arm)
        begin
          next_vbus_chg = 1'b0;
          next_vbus_arm = 1'b0;
        end
        if (!wdata_i[BIT_RESUME])
          next_resume_arm = 1'b1;
        else if (resume_arm)
        begin
          next_resume     = 1'b0;
          next_resume_arm = 1'b0;
        end
      end
    end
    if (vbus_edge)
      next_vbus_chg = 1'b1;
    if (resume_event)
      next_resume = 1'b1;
    if (dev_event)
      next_dev_chg = 1'b1;
    if (stage_event)
      next_ctrl_chg = 1'b1;
    if (setup_done_i)
      next_setup_rcv = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      vbus_chg   <= 1'b0;
      resume     <= 1'b0;
      dev_chg    <= 1'b0;
      ctrl_chg   <= 1'b0;
      setup_rcv  <= 1'b0;
      vbus_arm   <= 1'b0;
      resume_arm <= 1'b0;
    end
    else
    begin
      vbus_chg   <= next_vbus_chg & ~sw_reset_i;
      resume     <= next_resume & ~sw_reset_i;
      dev_chg    <= next_dev_chg & ~sw_reset_i;
      ctrl_chg   <= next_ctrl_chg & ~sw_reset_i;
      setup_rcv  <= next_setup_rcv & ~sw_reset_i;
      vbus_arm   <= next_vbus_arm & ~sw_reset_i;
      resume_arm <= next_resume_arm & ~sw_reset_i;
    end
  end

  // ----------------------------------------------------------------
  // Status word, read port and interrupt
  // ----------------------------------------------------------------
  logic [15:0] status_word, next_rdata;
  logic        next_irq;

  always_comb
  begin
    status_word                              = 16'h0000;
    status_word[BIT_VBUS_CHG]                = vbus_chg;
    status_word[BIT_RESUME]                  = resume;
    status_word[BIT_DEV_CHG]                 = dev_chg;
    status_word[BIT_CTRL_CHG]                = ctrl_chg;
    status_word[BIT_EMPTY_SUM]               = (|pipe_empty_overflow_flags_i)
                                               | ctrl_pipe_empty_overflow_flag_i;
    status_word[BIT_NRDY_SUM]                = (|pipe_not_ready_flags_i)
                                               | ctrl_pipe_not_ready_flag_i;
    status_word[BIT_RDY_SUM]                 = (|pipe_ready_flags_i) | ctrl_pipe_ready_flag_i;
    status_word[BIT_VBUS_LVL]                = vbus_i;
    status_word[DEV_STATE_LSB +: 3]          = dev_state;
    status_word[BIT_SETUP_RCV]               = setup_rcv;
    status_word[CTRL_STAGE_LSB +: 3]         = ctrl_stage;
  end

  always_comb
  begin
    next_rdata = 16'h0000;
    if (re_i)
    begin
      unique case (addr_i)
        OFS_MAIN:     next_rdata = status_word;
        OFS_SRC_EN:   next_rdata = {8'h00, src_en};
        OFS_IRQ_EN:   next_rdata = irq_en;
        OFS_CLK_CTRL: next_rdata = {15'h0000, clk_supply};
        OFS_PIPE_CTRL: next_rdata = {14'h0000, hshake};
        default:      next_rdata = 16'h0000;
      endcase
    end
    next_irq = |(status_word[15:8] & irq_en[15:8]);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= 16'h0000;
      irq_o   <= 1'b0;
    end
    else
    begin
      rdata_o <= sw_reset_i ? 16'h0000 : next_rdata;
      irq_o   <= next_irq & ~sw_reset_i;
    end
  end

endmodule

// ==== test/usi_status_props.sv ====
// Port-level assertions for the main status register block
`timescale 1ns/1ns
module usi_status_props
  import usi_pkg::*;
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              sw_reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              we_i,
  input wire logic              re_i,
  input wire logic [15:0]       rdata_o,
  // Pins and events
  input wire logic              vbus_i,
  input wire logic              usb_reset_det_i,
  input wire logic              set_address_exec_i,
  input wire logic              address_nonzero_i,
  input wire logic              set_config_exec_i,
  input wire logic              config_nonzero_i,
  input wire logic              suspend_det_i,
  // Outputs under check
  input wire logic [1:0]        response_handshake_field_o,
  input wire logic              internal_clock_supply_bit_o,
  input wire logic [2:0]        device_state_field_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_main_read;
    re_i && addr_i == OFS_MAIN;
  endsequence

  // No event of higher priority than a request is pending
  sequence s_no_higher_event;
    !sw_reset_i && !usb_reset_det_i && !suspend_det_i && !device_state_field_o[2];
  endsequence

  a_vbus_raw_read:
    assert property (s_main_read |=> rdata_o[BIT_VBUS_LVL] == $past(vbus_i))
    else $error("vbus level bit does not follow the pin");
  a_state_in_read:
    assert property (s_main_read |=> rdata_o[DEV_STATE_LSB +: 3] == $past(device_state_field_o))
    else $error("device state bits differ from the state output");
  a_bus_reset_state:
    assert property (usb_reset_det_i && !sw_reset_i |=> device_state_field_o == USI_DEV_DEFAULT)
    else $error("bus reset did not give the default state");
  a_address_state:
    assert property (s_no_higher_event ##0 set_address_exec_i
      |=> device_state_field_o == ($past(address_nonzero_i) ? USI_DEV_ADDRESS : USI_DEV_DEFAULT))
    else $error("set address gave the wrong state");
  a_config_state:
    assert property (s_no_higher_event ##0 set_config_exec_i && !set_address_exec_i
      |=> device_state_field_o == ($past(config_nonzero_i) ? USI_DEV_CONFIGURED : USI_DEV_ADDRESS))
    else $error("set configuration gave the wrong state");
  a_suspend_state:
    assert property (suspend_det_i && !usb_reset_det_i && !sw_reset_i |=> device_state_field_o[2])
    else $error("suspend did not give the suspended state");
  a_soft_reset_vals:
    assert property (sw_reset_i |=> device_state_field_o == USI_DEV_POWERED && !irq_o
      && internal_clock_supply_bit_o && rdata_o == 16'h0000)
    else $error("software reset left state behind");
  a_hshake_hold:
    assert property (!(we_i && addr_i == OFS_PIPE_CTRL) && !sw_reset_i |=> $stable(response_handshake_field_o))
    else $error("handshake field changed without a write");
endmodule

bind usi_status usi_status_props props_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .sw_reset_i(sw_reset_i), .addr_i(addr_i), .we_i(we_i), .re_i(re_i),
  .rdata_o(rdata_o), .vbus_i(vbus_i), .usb_reset_det_i(usb_reset_det_i), .set_address_exec_i(set_address_exec_i),
  .address_nonzero_i(address_nonzero_i), .set_config_exec_i(set_config_exec_i),
  .config_nonzero_i(config_nonzero_i), .suspend_det_i(suspend_det_i),
  .response_handshake_field_o(response_handshake_field_o),
  .internal_clock_supply_bit_o(internal_clock_supply_bit_o), .device_state_field_o(device_state_field_o),
  .irq_o(irq_o)
);

// ==== test/usi_host_model.sv ====
// Host-side model: VBUS supply and bus line state
`timescale 1ns/1ns
module usi_host_model
  import usi_pkg::*;
(
  // Clock
  input  wire logic  clk_i,
  // Bus pins
  output logic       vbus_o,
  output logic [1:0] line_o
);
  initial
  begin
    vbus_o = 1'b0;
    line_o = LINE_J;
  end

  // ----------------------------------------------------------------
  // Host actions
  // ----------------------------------------------------------------
  task automatic set_vbus(input logic lvl);
    @(posedge clk_i);
    vbus_o <= lvl;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic wake(input logic [1:0] ln);
    @(posedge clk_i);
    line_o <= ln;
    repeat (10) @(posedge clk_i);
    // Idle bus returns to J through the pull-up
    line_o <= LINE_J;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// ==== test/usb_device_status_interrupts_bench.sv ====
// Self-checking bench for the main status register block
`timescale 1ns/1ns
module usb_device_status_interrupts_bench
  import usi_pkg::*;
;
  localparam logic [8:0] EXP_CT = 9'h076;
  logic              clk_i;
  logic              rstn_i;
  logic              sw_reset_i;
  logic [ADDR_W-1:0] addr_i;
  logic [15:0]       wdata_i;
  logic              we_i;
  logic              re_i;
  logic [15:0]       rdata_o;
  logic              vbus_i;
  logic [1:0]        line_state_i;
  logic [4:0]        ev;
  logic              nz;
  logic [2:0]        ctrl_stage_i;
  logic [6:0]        fl [3];
  logic [1:0]        hs;
  logic              cks;
  logic [2:0]        dev_st;
  logic              irq_o;
  int                fails = 0;
  int                n_checks = 0;
  int                jj;
  int                kk;
  logic [2:0]        codes [9] = '{3'h1, 3'h2, 3'h0, 3'h3, 3'h4, 3'h0, 3'h5, 3'h6, 3'h7};

  usi_status #(.NUM_PIPES(6)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .sw_reset_i(sw_reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .vbus_i(vbus_i), .line_state_i(line_state_i),
    .usb_reset_det_i(ev[0]), .set_address_exec_i(ev[1]), .address_nonzero_i(nz), .set_config_exec_i(ev[2]),
    .config_nonzero_i(nz), .suspend_det_i(ev[3]), .setup_done_i(ev[4]), .ctrl_stage_i(ctrl_stage_i),
    .pipe_empty_overflow_flags_i(fl[0][5:0]), .ctrl_pipe_empty_overflow_flag_i(fl[0][6]),
    .pipe_not_ready_flags_i(fl[1][5:0]), .ctrl_pipe_not_ready_flag_i(fl[1][6]),
    .pipe_ready_flags_i(fl[2][5:0]), .ctrl_pipe_ready_flag_i(fl[2][6]), .response_handshake_field_o(hs),
    .internal_clock_supply_bit_o(cks), .device_state_field_o(dev_st), .irq_o(irq_o));
  usi_host_model host_u (.clk_i(clk_i), .vbus_o(vbus_i), .line_o(line_state_i));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    we_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i    <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_i);
    re_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1;
    chk(rdata_o & m, e);
  endtask

  // Flag clear followed by the spacing software owes between clears
  task automatic clr(input logic [15:0] d);
    wr(OFS_MAIN, d);
    repeat (CLEAR_SPACING_CYC) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input logic [4:0] s, input logic n);
    @(posedge clk_i);
    ev <= s;
    nz <= n;
    @(posedge clk_i);
    ev <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic step(input logic [4:0] s, input logic n, input logic [15:0] m, input logic [15:0] e);
    pulse(s, n);
    rchk(OFS_MAIN, m, e);
    clr(16'hEFFF);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    wrap_up();
  end

  initial
  begin
    rstn_i = 1'b0;
    {sw_reset_i, we_i, re_i, nz} = 4'h0;
    {ev, addr_i, wdata_i, ctrl_stage_i} = '0;
    fl = '{default: 7'h00};
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    rchk(OFS_MAIN, 16'hFFFF, 16'h0000);
    rchk(OFS_SRC_EN, 16'h00FF, {8'h00, SRC_EN_RST});
    rchk(OFS_IRQ_EN, 16'hFFFF, IRQ_EN_RST);
    rchk(OFS_CLK_CTRL, 16'h0001, {15'h0000, CLK_SUPPLY_RST});
    rchk(4'hA, 16'hFFFF, 16'h0000);
    host_u.set_vbus(1'b1);
    rchk(OFS_MAIN, 16'h8080, 16'h8080);
    rchk(OFS_MAIN, 16'h0080, 16'h0080);
    clr(16'h7FFF);
    rchk(OFS_MAIN, 16'h8000, 16'h0000);
    wr(OFS_IRQ_EN, 16'h8000);
    host_u.set_vbus(1'b0);
    chk({15'h0000, irq_o}, 16'h0001);
    clr(16'h7FFF);
    chk({15'h0000, irq_o}, 16'h0000);
    step(5'h01, 1'b0, 16'h1070, 16'h1010);
    step(5'h02, 1'b1, 16'h1070, 16'h1020);
    step(5'h02, 1'b0, 16'h1070, 16'h1010);
    step(5'h02, 1'b1, 16'h1070, 16'h1020);
    step(5'h04, 1'b1, 16'h1070, 16'h1030);
    step(5'h04, 1'b0, 16'h1070, 16'h1020);
    for (jj = 0; jj < 2; jj++)
    begin
      step(5'h04, 1'b1, 16'h1070, 16'h1030);
      step(5'h08, 1'b0, 16'h1040, 16'h1040);
      host_u.wake(jj == 0 ? LINE_K : LINE_SE0);
      rchk(OFS_MAIN, 16'h4070, 16'h4030);
      chk({13'h0000, dev_st}, 16'h0003);
      clr(16'hAFFF);
    end
    wr(OFS_SRC_EN, 16'h00FE);
    step(5'h01, 1'b0, 16'h1070, 16'h0010);
    wr(OFS_SRC_EN, 16'h00FF);
    wr(OFS_IRQ_EN, 16'hF7FF);
    pulse(5'h10, 1'b0);
    rchk(OFS_MAIN, 16'h0808, 16'h0808);
    chk({15'h0000, irq_o}, 16'h0000);
    wr(OFS_IRQ_EN, 16'h0000);
    wr(OFS_PIPE_CTRL, 16'h0003);
    rchk(OFS_PIPE_CTRL, 16'h0003, 16'h0000);
    clr(16'hE7F7);
    rchk(OFS_MAIN, 16'h1808, 16'h0000);
    wr(OFS_PIPE_CTRL, 16'h0003);
    chk({14'h0000, hs}, 16'h0003);
    wr(OFS_CLK_CTRL, 16'h0000);
    chk({15'h0000, cks}, 16'h0000);
    pulse(5'h10, 1'b0);
    clr(16'hE7F7);
    rchk(OFS_MAIN, 16'h0808, 16'h0808);
    host_u.set_vbus(1'b1);
    clr(16'h7FFF);
    rchk(OFS_MAIN, 16'h8000, 16'h8000);
    clr(16'hFFFF);
    rchk(OFS_MAIN, 16'h8000, 16'h0000);
    wr(OFS_CLK_CTRL, 16'h0001);
    clr(16'hE7F7);
    rchk(OFS_MAIN, 16'h0808, 16'h0000);
    // Sequence error source masked for the stage walk
    wr(OFS_SRC_EN, 16'h007F);
    foreach (codes[i])
    begin
      clr(16'hF7FF);
      @(posedge clk_i);
      ctrl_stage_i <= codes[i];
      repeat (3) @(posedge clk_i);
      rchk(OFS_MAIN, 16'h0807, {4'h0, EXP_CT[i], 8'h00, codes[i] == 3'h7 ? 3'h6 : codes[i]});
    end
    wr(OFS_SRC_EN, 16'h00FF);
    for (jj = 0; jj < 3; jj++)
    begin
      for (kk = 0; kk < 7; kk++)
      begin
        @(posedge clk_i);
        fl[jj] <= 7'h01 << kk;
        rchk(OFS_MAIN, 16'h0700, 16'h0400 >> jj);
      end
      @(posedge clk_i);
      fl[jj] <= 7'h00;
      rchk(OFS_MAIN, 16'h0700, 16'h0000);
    end
    wr(OFS_IRQ_EN, 16'hFFFF);
    host_u.set_vbus(1'b0);
    chk({15'h0000, irq_o}, 16'h0001);
    @(posedge clk_i);
    sw_reset_i <= 1'b1;
    @(posedge clk_i);
    sw_reset_i <= 1'b0;
    rchk(OFS_MAIN, 16'h9870, 16'h0000);
    chk({15'h0000, irq_o}, 16'h0000);
    wrap_up();
  end
endmodule
